// ===== pkg/mbps_defs.svh
`ifndef MBPS_DEFS_SVH
`define MBPS_DEFS_SVH

// ----------------------------------------------------------------------
// Command codes of the two priority registers
// ----------------------------------------------------------------------
`define MBPS_CMD_PRIO12      8'h27
`define MBPS_CMD_PRIO34      8'h28

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define MBPS_HI_LSB          4
`define MBPS_LO_LSB          0
`define MBPS_PRIO_RST        8'h00
`define MBPS_POLICE_SHED     8'hff

// ----------------------------------------------------------------------
// Timing of the serial shutdown code
// ----------------------------------------------------------------------
`define MBPS_CLK_NS          100
`define MBPS_BIT_SAMPLE_NS   2000
`define MBPS_GAP_MAX_NS      40000
// Least time, rounded up
`define MBPS_BIT_SAMPLE_CYC  ((`MBPS_BIT_SAMPLE_NS + `MBPS_CLK_NS - 1) / `MBPS_CLK_NS)
// Longest time, rounded down
`define MBPS_GAP_MAX_CYC     (`MBPS_GAP_MAX_NS / `MBPS_CLK_NS)

`endif

// ===== pkg/mbps_pkg.sv
package mbps_pkg;

    // Three-bit shed level and received shutdown code
    typedef logic [2:0] mbps_level_t;
    typedef logic [2:0] mbps_code_t;

    // Serial code receiver states, Gray along idle-high-wait-gap
    typedef enum logic [1:0] {
        MBPS_RX_IDLE = 2'b00,
        MBPS_RX_HIGH = 2'b01,
        MBPS_RX_WAIT = 2'b11,
        MBPS_RX_GAP  = 2'b10
    } mbps_rx_state_t;

endpackage

// ===== verilog/mbps_code_rx.sv
`timescale 1ns/10ps
`default_nettype none
`include "mbps_defs.svh"

module mbps_code_rx #(
    parameter int CNT_W      = 10,
    parameter int SAMPLE_CYC = `MBPS_BIT_SAMPLE_CYC,
    parameter int GAP_CYC    = `MBPS_GAP_MAX_CYC
) (
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic              fast_shutdown_input,
    output logic                   code_vld,
    output mbps_pkg::mbps_code_t   code
);
    import mbps_pkg::*;

    localparam logic [CNT_W-1:0] SAMPLE_C = CNT_W'(SAMPLE_CYC);
    localparam logic [CNT_W-1:0] GAP_C    = CNT_W'(GAP_CYC);

    typedef struct packed {
        mbps_rx_state_t   st;
        logic [CNT_W-1:0] cnt;
        logic [1:0]       nbits;
        logic [1:0]       sh;
        logic             vld;
        mbps_code_t       code;
    } mbps_rx_t;

    mbps_rx_t cur_ff;
    mbps_rx_t nxt_rx;

    // ------------------------------------------------------------------
    // Pulse-width decoding, MSB first
    // ------------------------------------------------------------------
    // Long pulse is a one, resolved at the sample point while still high
    always_comb begin
        logic bit_rdy;
        logic bit_val;
        bit_rdy = 1'b0;
        bit_val = 1'b0;
        nxt_rx = cur_ff;
        nxt_rx.vld = 1'b0;
        unique case (cur_ff.st)
            MBPS_RX_IDLE: begin
                nxt_rx.nbits = 2'h0;
                if (fast_shutdown_input) begin
                    nxt_rx.st  = MBPS_RX_HIGH;
                    nxt_rx.cnt = CNT_W'(1);
                end
            end
            MBPS_RX_HIGH: begin
                if (!fast_shutdown_input) begin
                    bit_rdy = 1'b1;        // Short pulse: zero
                    nxt_rx.cnt = '0;
                    nxt_rx.st = (cur_ff.nbits == 2'h2) ? MBPS_RX_IDLE : MBPS_RX_GAP;
                end else if (cur_ff.cnt == SAMPLE_C) begin
                    bit_rdy = 1'b1;
                    bit_val = 1'b1;
                    nxt_rx.st = MBPS_RX_WAIT;
                end else begin
                    nxt_rx.cnt = cur_ff.cnt + CNT_W'(1);
                end
            end
            MBPS_RX_WAIT: begin
                if (!fast_shutdown_input) begin
                    nxt_rx.cnt = '0;
                    nxt_rx.st = (cur_ff.nbits == 2'h0) ? MBPS_RX_IDLE : MBPS_RX_GAP;
                end
            end
            MBPS_RX_GAP: begin
                if (fast_shutdown_input) begin
                    nxt_rx.st  = MBPS_RX_HIGH;
                    nxt_rx.cnt = CNT_W'(1);
                end else if (cur_ff.cnt == GAP_C) begin
                    nxt_rx.st    = MBPS_RX_IDLE;   // Abandon a broken code
                    nxt_rx.nbits = 2'h0;
                end else begin
                    nxt_rx.cnt = cur_ff.cnt + CNT_W'(1);
                end
            end
        endcase
        // Shift the resolved bit; third bit releases the code at once
        if (bit_rdy) begin
            nxt_rx.sh = {cur_ff.sh[0], bit_val};
            if (cur_ff.nbits == 2'h2) begin
                nxt_rx.vld   = 1'b1;
                nxt_rx.code  = {cur_ff.sh, bit_val};
                nxt_rx.nbits = 2'h0;
            end else begin
                nxt_rx.nbits = cur_ff.nbits + 2'h1;
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cur_ff <= '{st: MBPS_RX_IDLE, cnt: '0, nbits: 2'h0, sh: 2'h0,
                        vld: 1'b0, code: 3'h0};
        end else begin
            cur_ff <= nxt_rx;
        end
    end

    assign code_vld = cur_ff.vld;
    assign code     = cur_ff.code;

endmodule // mbps_code_rx

`default_nettype wire

// ===== verilog/mbps_shed.sv
// How it works
// - Register 27h holds channel 2 and 1 levels.
// - Register 28h holds channels 4, 3; reset zero.
// - Levels shed channels only with multilevel select.
// - Lower level means higher priority, seven shed first.
// - Level 000 needs code 000; 001 needs 000/001.
// - Level 101 shed by any code except 111.
// - Level 111 always shed; equal levels shed together.
// - Shed clears channel state, keeps cool-down timer running.
// - Shed clears status, flags, measurements; policing to FFh.
// - Each code acts at once, no memory kept.
`timescale 1ns/10ps
`default_nettype none
`include "mbps_defs.svh"

module mbps_shed #(
    parameter int NCH        = 4,
    parameter int CNT_W      = 10,
    parameter int SAMPLE_CYC = `MBPS_BIT_SAMPLE_CYC,
    parameter int GAP_CYC    = `MBPS_GAP_MAX_CYC
) (
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    // Command-addressed register port
    input  wire logic              cmd_valid,
    input  wire logic              cmd_write,
    input  wire logic [7:0]        cmd_code,
    input  wire logic [7:0]        cmd_wdata,
    output logic [7:0]             cmd_rdata_ff,
    output logic                   cmd_rvalid_ff,
    // Mode select from the general mask register
    input  wire logic              multilevel_shed_select,
    // Serial shutdown code input
    input  wire logic              fast_shutdown_input,
    // Channel reset command, one pulse per channel
    input  wire logic [NCH-1:0]    chan_reset_cmd,
    // Actions towards the channel logic
    output logic [NCH-1:0]         chan_clear_ff,
    output logic [NCH-1:0]         cooldown_cancel_ff,
    output logic [NCH-1:0]         police_load_ff,
    output logic [7:0]             police_limit_ff,
    output logic [NCH-1:0]         shed_mask_ff,
    output mbps_pkg::mbps_code_t   last_code_ff,
    output logic                   code_seen_ff
);
    import mbps_pkg::*;

    // ------------------------------------------------------------------
    // State of the block
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]     prio12;
        logic [7:0]     prio34;
        logic [7:0]     rdata;
        logic           rvalid;
        logic [NCH-1:0] clear;
        logic [NCH-1:0] cancel;
        logic [NCH-1:0] pload;
        logic [7:0]     plimit;
        logic [NCH-1:0] shed;
        mbps_code_t     code;
        logic           seen;
    } mbps_state_t;

    mbps_state_t cur_ff;
    mbps_state_t nxt_st;

    logic        code_vld;
    mbps_code_t  code;
    mbps_level_t level [NCH];
    logic [NCH-1:0] shed_hit;

    // ------------------------------------------------------------------
    // Serial code receiver
    // ------------------------------------------------------------------
    mbps_code_rx #(
        .CNT_W      (CNT_W),
        .SAMPLE_CYC (SAMPLE_CYC),
        .GAP_CYC    (GAP_CYC)
    ) u_code_rx (
        .clk_sys             (clk_sys),
        .rst_n               (rst_n),
        .fast_shutdown_input (fast_shutdown_input),
        .code_vld            (code_vld),
        .code                (code)
    );

    // ------------------------------------------------------------------
    // Level fields of each channel
    // ------------------------------------------------------------------
    // Channel n level is the low or high half of its register
    always_comb begin
        level[0] = cur_ff.prio12[`MBPS_LO_LSB +: 3];
        level[1] = cur_ff.prio12[`MBPS_HI_LSB +: 3];
        level[2] = cur_ff.prio34[`MBPS_LO_LSB +: 3];
        level[3] = cur_ff.prio34[`MBPS_HI_LSB +: 3];
    end

    // ------------------------------------------------------------------
    // Shed decision per channel
    // ------------------------------------------------------------------
    // Code not above the level sheds; 000 sheds all, 111 sheds only
    // level 111, so equal levels fall together. Level 101 also falls
    // to code 110: every code but 111 takes it
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_cmp
            assign shed_hit[gi] = code_vld
                               && multilevel_shed_select
                               && ((code <= level[gi])
                                   || ((level[gi] == 3'h5)
                                       && (code != 3'h7)));
        end
    endgenerate

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st = cur_ff;
        nxt_st.rvalid = 1'b0;
        nxt_st.clear  = '0;
        nxt_st.cancel = '0;
        nxt_st.pload  = '0;

        // Register writes
        if (cmd_valid && cmd_write) begin
            if (cmd_code == `MBPS_CMD_PRIO12) begin
                nxt_st.prio12 = cmd_wdata;
            end
            if (cmd_code == `MBPS_CMD_PRIO34) begin
                nxt_st.prio34 = cmd_wdata;
            end
        end

        // Register reads, answered one cycle later
        if (cmd_valid && !cmd_write) begin
            if (cmd_code == `MBPS_CMD_PRIO12) begin
                nxt_st.rdata  = cur_ff.prio12;
                nxt_st.rvalid = 1'b1;
            end
            if (cmd_code == `MBPS_CMD_PRIO34) begin
                nxt_st.rdata  = cur_ff.prio34;
                nxt_st.rvalid = 1'b1;
            end
        end

        // A code drives its own clears only; nothing carries over
        if (code_vld) begin
            nxt_st.code = code;
            nxt_st.seen = 1'b1;
            nxt_st.shed = shed_hit;
        end

        // Shed clears state but leaves cool-down timers running
        nxt_st.clear = shed_hit | chan_reset_cmd;
        nxt_st.pload = shed_hit | chan_reset_cmd;
        nxt_st.cancel = chan_reset_cmd;
        nxt_st.plimit = `MBPS_POLICE_SHED;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cur_ff <= '{prio12: `MBPS_PRIO_RST,
                        prio34: `MBPS_PRIO_RST,
                        rdata:  8'h00,
                        rvalid: 1'b0,
                        clear:  '0,
                        cancel: '0,
                        pload:  '0,
                        plimit: `MBPS_POLICE_SHED,
                        shed:   '0,
                        code:   3'h0,
                        seen:   1'b0};
        end else begin
            cur_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs straight from the state register
    // ------------------------------------------------------------------
    assign cmd_rdata_ff       = cur_ff.rdata;
    assign cmd_rvalid_ff      = cur_ff.rvalid;
    assign chan_clear_ff      = cur_ff.clear;
    assign cooldown_cancel_ff = cur_ff.cancel;
    assign police_load_ff     = cur_ff.pload;
    assign police_limit_ff    = cur_ff.plimit;
    assign shed_mask_ff       = cur_ff.shed;
    assign last_code_ff       = cur_ff.code;
    assign code_seen_ff       = cur_ff.seen;

endmodule // mbps_shed

`default_nettype wire

// ===== tb/mbps_host_model.sv
`timescale 1ns/10ps
`default_nettype none

module mbps_host_model #(
    parameter int SAMPLE_CYC = 4
) (
    input  wire logic clk_sys,
    output logic      fast_shutdown_input
);
    // Line idles low between codes
    initial fast_shutdown_input = 1'b0;

    // Three pulses MSB first, long pulse a one, short a zero
    task automatic send(input logic [2:0] code);
        for (int i = 2; i >= 0; i--) begin
            @(posedge clk_sys);
            fast_shutdown_input <= 1'b1;
            repeat (code[i] ? SAMPLE_CYC + 2 : 1) @(posedge clk_sys);
            fast_shutdown_input <= 1'b0;
            repeat (3) @(posedge clk_sys);
        end
    endtask
endmodule // mbps_host_model

`default_nettype wire

// ===== tb/mbps_shed_sva.sv
`timescale 1ns/10ps
`default_nettype none

module mbps_shed_sva #(
    parameter int NCH = 4
) (
    input wire logic                 clk_sys,
    input wire logic                 rst_n,
    input wire logic                 cmd_valid,
    input wire logic                 cmd_write,
    input wire logic [7:0]           cmd_code,
    input wire logic [7:0]           cmd_rdata_ff,
    input wire logic                 cmd_rvalid_ff,
    input wire logic                 multilevel_shed_select,
    input wire logic [NCH-1:0]       chan_reset_cmd,
    input wire logic [NCH-1:0]       chan_clear_ff,
    input wire logic [NCH-1:0]       cooldown_cancel_ff,
    input wire logic [NCH-1:0]       police_load_ff,
    input wire logic [7:0]           police_limit_ff,
    input wire logic [NCH-1:0]       shed_mask_ff,
    input wire mbps_pkg::mbps_code_t last_code_ff,
    input wire logic                 code_seen_ff
);
    import mbps_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // Channel actions
    a_police_const: assert property (police_limit_ff == 8'hff)
        else $error("policing limit not ff");
    a_cancel_reset: assert property ($past(rst_n) |-> cooldown_cancel_ff == $past(chan_reset_cmd))
        else $error("cool-down cancel without channel reset");
    a_pload_clear: assert property (police_load_ff == chan_clear_ff)
        else $error("policing load apart from clear");
    a_clear_cause: assert property ($past(rst_n) |->
        ((chan_clear_ff & ~$past(chan_reset_cmd) & ~shed_mask_ff) == '0))
        else $error("clear without cause");
    a_mask_action: assert property ($changed(shed_mask_ff) && shed_mask_ff != '0 |->
        $past(multilevel_shed_select) && ((chan_clear_ff & shed_mask_ff) == shed_mask_ff))
        else $error("shed mask without clear");
    // Register port and code-seen flag
    a_read_answer: assert property (cmd_valid && !cmd_write &&
        (cmd_code == 8'h27 || cmd_code == 8'h28) |=> cmd_rvalid_ff)
        else $error("mapped read not answered");
    a_unmapped_quiet: assert property (!(cmd_valid && !cmd_write &&
        (cmd_code == 8'h27 || cmd_code == 8'h28)) |=> !cmd_rvalid_ff)
        else $error("answer without mapped read");
    a_seen_sticky: assert property (code_seen_ff |=> code_seen_ff)
        else $error("code seen flag dropped");
endmodule // mbps_shed_sva

bind mbps_shed mbps_shed_sva #(.NCH(NCH)) u_mbps_shed_sva (
    .clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_rdata_ff(cmd_rdata_ff), .cmd_rvalid_ff(cmd_rvalid_ff),
    .multilevel_shed_select(multilevel_shed_select), .chan_reset_cmd(chan_reset_cmd),
    .chan_clear_ff(chan_clear_ff), .cooldown_cancel_ff(cooldown_cancel_ff),
    .police_load_ff(police_load_ff), .police_limit_ff(police_limit_ff),
    .shed_mask_ff(shed_mask_ff), .last_code_ff(last_code_ff), .code_seen_ff(code_seen_ff));

`default_nettype wire

// ===== tb/multibit_priority_port_shed_test.sv
`timescale 1ns/10ps
`default_nettype none

module multibit_priority_port_shed_test;
    import mbps_pkg::*;
    logic       clk_sys, rst_n, cmd_valid, cmd_write, sel, fsi, rvalid, seen, mon;
    logic [7:0] cmd_code, cmd_wdata, rdata, plim, w27, w28;
    logic [3:0] rst_cmd, clr, ccl, pld, mask, clr_acc, ccl_acc, pld_acc, e;
    mbps_code_t last_code;
    int         miscompares = 0, num_checks = 0, seed = 25, lv[4];

    mbps_shed #(.NCH(4), .CNT_W(10), .SAMPLE_CYC(4), .GAP_CYC(16)) u_mbps_shed (
        .clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata_ff(rdata),
        .cmd_rvalid_ff(rvalid), .multilevel_shed_select(sel), .fast_shutdown_input(fsi),
        .chan_reset_cmd(rst_cmd), .chan_clear_ff(clr), .cooldown_cancel_ff(ccl),
        .police_load_ff(pld), .police_limit_ff(plim), .shed_mask_ff(mask),
        .last_code_ff(last_code), .code_seen_ff(seen));
    mbps_host_model #(.SAMPLE_CYC(4)) u_mbps_host_model (.clk_sys(clk_sys),
        .fast_shutdown_input(fsi));

    // ------------------------------------------------------------------
    // Clock, monitor and helpers
    // ------------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // Gather action pulses during a code
    always @(posedge clk_sys) begin
        if (mon) begin
            clr_acc = clr_acc | clr;
            ccl_acc = ccl_acc | ccl;
            pld_acc = pld_acc | pld;
        end
    end

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic cmd(input logic wr, input logic [7:0] code, input logic [7:0] data);
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd_write <= wr;
        cmd_code  <= code;
        cmd_wdata <= data;
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] code, input logic [7:0] exp);
        logic hit;
        hit = (code == 8'h27) || (code == 8'h28);
        cmd(1'b0, code, 8'h00);
        chk("read_valid", {7'h00, hit}, {7'h00, rvalid});
        if (hit) chk("read_data", exp, rdata);
    endtask

    // Send one code, compare against level model
    task automatic shed(input logic [2:0] code);
        clr_acc = 4'h0;
        ccl_acc = 4'h0;
        pld_acc = 4'h0;
        mon = 1'b1;
        u_mbps_host_model.send(code);
        repeat (4) @(posedge clk_sys);
        mon = 1'b0;
        // Level 5 falls to every code but 7; other levels to codes not above them
        for (int c = 0; c < 4; c++) begin
            e[c] = sel && ((lv[c] == 5) ? (code != 3'h7) : (int'(code) <= lv[c]));
        end
        chk("shed_mask", {4'h0, e}, {4'h0, mask});
        chk("clear", {4'h0, e}, {4'h0, clr_acc});
        chk("cancel", 8'h00, {4'h0, ccl_acc});
        chk("police_load", {4'h0, e}, {4'h0, pld_acc});
        chk("last_code", {5'h00, code}, {5'h00, last_code});
        chk("code_seen", 8'h01, {7'h00, seen});
    endtask

    // Hang guard
    initial begin
        repeat (60000) @(posedge clk_sys);
        miscompares++;
        $display("unexpected timeout: expected end seen none");
        tally_and_finish();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 8'h00;
        sel = 1'b0;
        rst_cmd = 4'h0;
        mon = 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(8'h27, 8'h00);
        rd(8'h28, 8'h00);
        chk("police_limit", 8'hff, plim);
        chk("code_seen", 8'h00, {7'h00, seen});
        for (int r = 0; r < 16; r++) begin
            w27 = $random(seed);
            w28 = $random(seed);
            // Channel 1 at level 5 when codes 6 and 7 are sent
            if (r[2:1] == 2'b11) w27[2:0] = 3'h5;
            lv = '{int'(w27[2:0]), int'(w27[6:4]), int'(w28[2:0]), int'(w28[6:4])};
            cmd(1'b1, 8'h27, w27);
            cmd(1'b1, 8'h28, w28);
            rd(8'h27, w27);
            rd(8'h28, w28);
            rd(8'h29, 8'h00);
            sel <= (r < 14);
            shed(r[2:0]);
            @(posedge clk_sys);
            rst_cmd <= 4'($random(seed));
            @(posedge clk_sys);
            e = rst_cmd;
            rst_cmd <= 4'h0;
            #1;
            chk("reset_clear", {4'h0, e}, {4'h0, clr});
            chk("reset_cancel", {4'h0, e}, {4'h0, ccl});
        end
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(8'h27, 8'h00);
        chk("code_seen", 8'h00, {7'h00, seen});
        chk("shed_mask", 8'h00, {4'h0, mask});
        tally_and_finish();
    end
endmodule // multibit_priority_port_shed_test

`default_nettype wire
